// file: hdl/acb_sequencer.sv
// charge-target automatic cell balance sequencer
`timescale 1ns/10ps

// Operation
// - each target holds voltage times cycles; one measured voltage removed per period
// - after each interval subtract fresh voltage; cell done when target reaches zero
// - fourteen 16-bit discharge target registers, one per cell
// - target register is upper 16 bits of a 24-bit accumulator
// - scan every cell at end of each on-time; results feed subtraction
// - exhausted cell's output stops; other cells keep balancing
// - all targets zero sets done flag and clears run bit
// - inhibit halts balancing and keeps target contents
// - restart after inhibit begins again at pattern register one
// - targets then patterns at consecutive addresses from 0xA0
// - setup at 0x90 and guard/period timer adjacent at 0x91
// - rest code 100 gives an 8 second gap between cycles
// - method code 11 selects this automatic balancing mode
// - pause bit set turns outputs off during scans
// - period code selects on-time; 3 is one minute, 15 five minutes
// - guard register low byte is watchdog setting, default 3F
// - pattern bit k-1 enables cell k balance output
// - patterns applied in order, wrapping to first at a zero pattern
// - cycle repeats every period plus rest; rest codes give 0..64 seconds
// - watchdog expiry ends balancing, sets timeout flag, enters sleep
module acb_sequencer #(
   parameter int STEP_CYCLES = acb_pkg::PERIOD_STEP_S * acb_pkg::CLK_HZ,
   parameter int SEC_CYCLES = acb_pkg::REST_UNIT_S * acb_pkg::CLK_HZ,
   parameter int LEAD_CYCLES = acb_pkg::PAUSE_LEAD_MS * (acb_pkg::CLK_HZ / 1000),
   parameter int WDOG_TICK_CYCLES = acb_pkg::WDOG_UNIT_S * acb_pkg::CLK_HZ
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire acb_pkg::acb_reg_req_type reg_req,
   output logic [15:0] reg_rdata,
   input wire logic cmd_balance_enable,
   input wire logic cmd_balance_inhibit,
   output logic scan_req,
   input wire logic scan_done,
   input wire acb_pkg::acb_volt_arr_type scan_volt,
   output logic [acb_pkg::NCELL-1:0] cell_balance_en,
   output logic balance_run_bit,
   output logic balance_done_flag,
   output logic wdog_timeout_flag,
   output logic sleep_req
);

   typedef struct packed {
      acb_pkg::acb_fsm_type fsm;
      logic run;
      logic done;
      logic wdt;
      logic sleep;
      logic [3:0] idx;
      logic [39:0] timer;
      logic [31:0] wdog_pre;
      logic [7:0] wdog_ticks;
      logic [15:0] setup;
      logic [15:0] guard;
      logic [acb_pkg::NCELL-1:0][acb_pkg::ACC_W-1:0] acc;
      logic [acb_pkg::NCELL-1:0][acb_pkg::NCELL-1:0] pat;
      logic [acb_pkg::NCELL-1:0] bal_en;
      logic [15:0] rdata;
   } acb_state_type;

   acb_state_type q, d;

   localparam logic [39:0] STEP40 = 40'(STEP_CYCLES);
   localparam logic [39:0] SEC40 = 40'(SEC_CYCLES);
   localparam logic [39:0] LEAD40 = 40'(LEAD_CYCLES);
   localparam logic [31:0] WTICK32 = 32'(WDOG_TICK_CYCLES);

   // field views of the setup and guard registers
   logic [1:0] method_q;
   logic [2:0] rest_sel_q;
   logic pause_q;
   logic [6:0] period_code_q;
   logic [7:0] wdog_set_q;
   logic [acb_pkg::NCELL-1:0] active_q;
   logic [39:0] period_cycles;
   logic [39:0] rest_cycles;

   assign method_q = q.setup[acb_pkg::SETUP_METHOD_LSB +: 2];
   assign rest_sel_q = q.setup[acb_pkg::SETUP_REST_LSB +: 3];
   assign pause_q = q.setup[acb_pkg::SETUP_PAUSE_BIT];
   assign period_code_q = q.guard[acb_pkg::GUARD_PERIOD_LSB +: 7];
   assign wdog_set_q = q.guard[7:0];

   // live cells: nonzero accumulator
   always_comb begin
      for (int i = 0; i < acb_pkg::NCELL; i++) begin
         active_q[i] = (q.acc[i] != '0);
      end
   end

   // period is code times 20 s; code 0 treated as one step
   always_comb begin
      period_cycles = 40'(period_code_q) * STEP40;
      if (period_code_q == 7'h00) begin
         period_cycles = STEP40;
      end
   end

   // rest codes 0,1,2,4..64 seconds; code 100 gives 8 s
   always_comb begin
      rest_cycles = '0;
      if (rest_sel_q != 3'h0) begin
         rest_cycles = (40'h01 << (rest_sel_q - 3'h1)) * SEC40;
      end
   end

   // next state
   always_comb begin
      logic [24:0] diff;
      logic [4:0] rel;
      logic start;
      logic stop;
      logic comm;
      logic [3:0] nidx;
      logic [acb_pkg::NCELL-1:0] live_d;
      diff = '0;
      rel = 5'(reg_req.addr - acb_pkg::ADDR_TGT_BASE);
      start = 1'b0;
      stop = 1'b0;
      comm = reg_req.wr | reg_req.rd | cmd_balance_enable | cmd_balance_inhibit;
      nidx = '0;
      live_d = '0;
      d = q;

      // register reads answer the cycle after the request, unmapped reads as zero
      if (reg_req.rd) begin
         d.rdata = 16'h0000;
         if (reg_req.addr == acb_pkg::ADDR_SETUP) begin
            d.rdata = q.setup;
            d.rdata[acb_pkg::SETUP_RUN_BIT] = q.run;
         end else if (reg_req.addr == acb_pkg::ADDR_GUARD) begin
            d.rdata = q.guard;
         end else if (reg_req.addr >= acb_pkg::ADDR_TGT_BASE &&
                      reg_req.addr < acb_pkg::ADDR_BLOCK_END) begin
            // software sees the upper 16 bits
            if (rel < 5'(acb_pkg::NCELL)) begin
               d.rdata = q.acc[rel[3:0]][acb_pkg::ACC_W-1 -: acb_pkg::TGT_W];
            end else begin
               d.rdata = 16'(q.pat[4'(rel - 5'(acb_pkg::NCELL))]);
            end
         end
      end

      // register writes; targets load the accumulator top
      if (reg_req.wr) begin
         if (reg_req.addr == acb_pkg::ADDR_SETUP) begin
            d.setup = reg_req.wdata;
            if (reg_req.wdata[acb_pkg::SETUP_RUN_BIT]) begin
               start = 1'b1;
            end else begin
               stop = 1'b1;
            end
         end else if (reg_req.addr == acb_pkg::ADDR_GUARD) begin
            d.guard = reg_req.wdata;
         end else if (reg_req.addr >= acb_pkg::ADDR_TGT_BASE &&
                      reg_req.addr < acb_pkg::ADDR_BLOCK_END) begin
            if (rel < 5'(acb_pkg::NCELL)) begin
               d.acc[rel[3:0]] = {reg_req.wdata, {acb_pkg::ACC_LSB_SHIFT{1'b0}}};
            end else begin
               d.pat[4'(rel - 5'(acb_pkg::NCELL))] = reg_req.wdata[acb_pkg::NCELL-1:0];
            end
         end
      end
      if (cmd_balance_enable) begin
         start = 1'b1;
      end

      // watchdog: any link activity restarts it; setting 0 disables it
      d.wdog_pre = q.wdog_pre + 32'h1;
      if (q.wdog_pre >= WTICK32 - 32'h1) begin
         d.wdog_pre = '0;
         d.wdog_ticks = q.wdog_ticks + 8'h01;
      end
      if (comm || wdog_set_q == 8'h00) begin
         d.wdog_pre = '0;
         d.wdog_ticks = '0;
         d.sleep = 1'b0;
      end

      // sequencer
      case (q.fsm)
         acb_pkg::ST_IDLE: begin
            d.timer = '0;
         end
         acb_pkg::ST_ON: begin
            d.timer = q.timer + 40'h1;
            if (q.timer >= period_cycles - 40'h1) begin
               d.timer = '0;
               // the lead-off gap only exists when scans pause balancing
               d.fsm = pause_q ? acb_pkg::ST_LEAD : acb_pkg::ST_SCAN;
            end
         end
         acb_pkg::ST_LEAD: begin
            d.timer = q.timer + 40'h1;
            if (q.timer >= LEAD40 - 40'h1) begin
               d.timer = '0;
               d.fsm = acb_pkg::ST_SCAN;
            end
         end
         acb_pkg::ST_SCAN: begin
            // scan of every cell closes each on-time
            // an inhibit or run bit written low in the same cycle drops the reading so targets stay as they were; watchdog expiry does not
            if (scan_done && !cmd_balance_inhibit && !stop) begin
               for (int i = 0; i < acb_pkg::NCELL; i++) begin
                  // subtract only from cells balanced in this interval
                  if (q.pat[q.idx][i] && active_q[i]) begin
                     diff = {1'b0, q.acc[i]} - 25'(scan_volt[i]);
                     // going below zero clamps and finishes the cell
                     d.acc[i] = diff[24] ? '0 : diff[23:0];
                  end
               end
               // next pattern, wrap at a zero pattern or the last one
               nidx = q.idx + 4'h1;
               if (q.idx == 4'(acb_pkg::NCELL - 1) || q.pat[nidx] == '0) begin
                  nidx = '0;
               end
               d.idx = nidx;
               d.fsm = (rest_cycles == '0) ? acb_pkg::ST_ON : acb_pkg::ST_REST;
            end
         end
         acb_pkg::ST_REST: begin
            d.timer = q.timer + 40'h1;
            if (q.timer >= rest_cycles - 40'h1) begin
               d.timer = '0;
               d.fsm = acb_pkg::ST_ON;
            end
         end
         default: begin
            d.fsm = acb_pkg::ST_IDLE;
         end
      endcase

      // all targets exhausted: done, run cleared
      for (int i = 0; i < acb_pkg::NCELL; i++) begin
         live_d[i] = (d.acc[i] != '0);
      end
      if (q.run && live_d == '0) begin
         d.run = 1'b0;
         d.done = 1'b1;
         d.fsm = acb_pkg::ST_IDLE;
      end

      // start only in the charge-target method; always from pattern one
      if (start && !q.run && method_q == acb_pkg::METHOD_AUTO) begin
         d.run = 1'b1;
         d.done = 1'b0;
         d.wdt = 1'b0;
         d.idx = '0;
         d.timer = '0;
         d.fsm = acb_pkg::ST_ON;
         if (live_d == '0) begin
            d.run = 1'b0;
            d.done = 1'b1;
            d.fsm = acb_pkg::ST_IDLE;
         end
      end

      // inhibit or run bit written low halts, accumulators untouched
      if (cmd_balance_inhibit || stop) begin
         d.run = 1'b0;
         d.idx = '0;
         d.timer = '0;
         d.fsm = acb_pkg::ST_IDLE;
      end

      // watchdog expiry overrides run, index, timer and state; a reading taken in the same cycle is still subtracted
      if (!comm && wdog_set_q != 8'h00 && q.wdog_ticks >= wdog_set_q) begin
         d.run = 1'b0;
         d.wdt = 1'b1;
         d.sleep = 1'b1;
         d.idx = '0;
         d.timer = '0;
         d.wdog_ticks = '0;
         d.fsm = acb_pkg::ST_IDLE;
      end

      // drive only live cells; off during scan when pausing
      d.bal_en = '0;
      // pause bit taken from the next setup so a write during a scan acts at once
      if (d.fsm == acb_pkg::ST_ON ||
          (d.fsm == acb_pkg::ST_SCAN && !d.setup[acb_pkg::SETUP_PAUSE_BIT])) begin
         d.bal_en = d.pat[d.idx] & live_d;
      end
   end

   // state register; reset acts regardless of ce
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         q <= '0;
         q.fsm <= acb_pkg::ST_IDLE;
         q.setup <= acb_pkg::SETUP_RESET;
         q.guard <= acb_pkg::GUARD_RESET;
      end else if (ce) begin
         q <= d;
      end
   end

   // outputs; scan request is a handshake level from the state
   assign reg_rdata = q.rdata;
   assign scan_req = (q.fsm == acb_pkg::ST_SCAN);
   assign cell_balance_en = q.bal_en;
   assign balance_run_bit = q.run;
   assign balance_done_flag = q.done;
   assign wdog_timeout_flag = q.wdt;
   assign sleep_req = q.sleep;

   // checks
   a_dead_cell_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      q.acc[0] == '0 |-> !cell_balance_en[0])
      else $error("balance output driven on a cell with zero target");

   a_done_stops_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(balance_done_flag) |-> !balance_run_bit && cell_balance_en == '0)
      else $error("done flag set while still running");

   a_inhibit_halts: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ce && cmd_balance_inhibit && !reg_req.wr |=> !balance_run_bit && cell_balance_en == '0
         && q.acc == $past(q.acc))
      else $error("inhibit did not halt or changed targets");

   a_restart_first_pat: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ce && cmd_balance_inhibit |=> q.idx == 4'h0)
      else $error("pattern index not rewound by inhibit");

   a_pause_scan_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      scan_req && pause_q |-> cell_balance_en == '0)
      else $error("balance outputs on during paused scan");

   a_method_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(balance_run_bit) |-> $past(method_q) == acb_pkg::METHOD_AUTO)
      else $error("run started outside charge-target method");

   a_wdog_sleep: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(wdog_timeout_flag) |-> sleep_req && !balance_run_bit ##1 cell_balance_en == '0)
      else $error("watchdog expiry did not end balancing");

   a_acc_no_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !reg_req.wr |=> q.acc[0] <= $past(q.acc[0]))
      else $error("accumulator grew without a write");

   a_guard_default: assert property (@(posedge ref_clk)
      !rst_n |=> wdog_set_q == acb_pkg::GUARD_RESET[7:0])
      else $error("watchdog setting default wrong");

   a_pattern_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ce && scan_done && scan_req && !reg_req.wr && !cmd_balance_inhibit
         && q.idx != 4'(acb_pkg::NCELL - 1) && q.pat[q.idx + 4'h1] == '0 |=> q.idx == 4'h0)
      else $error("pattern sequence did not wrap at zero pattern");

   // a stopped engine never leaves an output on
   a_idle_outputs: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !balance_run_bit |-> cell_balance_en == '0)
      else $error("balance output on while not running");

   c_finish: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(balance_done_flag));
   c_wrap: cover property (@(posedge ref_clk) disable iff (!rst_n)
      scan_req && scan_done && q.idx != 4'h0 ##1 q.idx == 4'h0);
   c_inhibit: cover property (@(posedge ref_clk) disable iff (!rst_n)
      balance_run_bit && cmd_balance_inhibit);
   c_wdog: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(wdog_timeout_flag));
   c_pause_scan: cover property (@(posedge ref_clk) disable iff (!rst_n)
      scan_req && pause_q);

endmodule

// file: hdl/acb_pkg.sv
// shared constants and types for the charge-target balance sequencer
package acb_pkg;

   localparam int NCELL = 14;
   localparam int ACC_W = 24;
   localparam int TGT_W = 16;
   localparam int VOLT_W = 14;
   localparam int ACC_LSB_SHIFT = ACC_W - TGT_W;

   // register map
   localparam logic [7:0] ADDR_SETUP = 8'h90;
   localparam logic [7:0] ADDR_GUARD = 8'h91;
   localparam logic [7:0] ADDR_TGT_BASE = 8'hA0;
   localparam logic [7:0] ADDR_PAT_BASE = 8'hAE;
   localparam logic [7:0] ADDR_BLOCK_END = 8'hBC;

   // balance_setup fields
   localparam int SETUP_METHOD_LSB = 0;
   localparam int SETUP_REST_LSB = 2;
   localparam int SETUP_RUN_BIT = 5;
   localparam int SETUP_PAUSE_BIT = 6;
   localparam logic [1:0] METHOD_AUTO = 2'h3;
   localparam logic [15:0] SETUP_RESET = 16'h0000;

   // guard_and_period_timer fields
   localparam int GUARD_PERIOD_LSB = 8;
   localparam logic [15:0] GUARD_RESET = 16'h003F;

   // timing, figures in their own units
   localparam int CLK_HZ = 10_000_000;
   localparam int PERIOD_STEP_S = 20;
   localparam int REST_UNIT_S = 1;
   localparam int PAUSE_LEAD_MS = 10;
   localparam int WDOG_UNIT_S = 1;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } acb_reg_req_type;

   typedef logic [NCELL-1:0][VOLT_W-1:0] acb_volt_arr_type;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ON = 5'h02,
      ST_LEAD = 5'h04,
      ST_SCAN = 5'h08,
      ST_REST = 5'h10
   } acb_fsm_type;

endpackage

// file: verif/acb_scan_model.sv
// scan engine stand-in that answers balance scans with programmed cell voltages
`timescale 1ns/10ps

module acb_scan_model (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic scan_req,
   input wire logic [7:0] resp_delay,
   input wire acb_pkg::acb_volt_arr_type volt_in,
   output logic scan_done,
   output acb_pkg::acb_volt_arr_type scan_volt
);
   logic [7:0] cnt_q;
   logic armed_q;

   // one answer per request; the data bus is scrambled outside the done pulse
   // so that a stale value can never be taken for a fresh measurement
   always @(posedge ref_clk) begin
      scan_done <= 1'b0;
      scan_volt <= ~scan_volt;
      if (!rst_n) begin
         cnt_q <= 8'h00;
         armed_q <= 1'b1;
         scan_volt <= '0;
      end else if (!scan_req) begin
         armed_q <= 1'b1;
         cnt_q <= 8'h00;
      end else if (armed_q) begin
         cnt_q <= cnt_q + 8'h01;
         if (cnt_q == resp_delay) begin
            scan_done <= 1'b1;
            scan_volt <= volt_in;
            armed_q <= 1'b0;
         end
      end
   end
endmodule

// file: verif/acb_sequencer_test.sv
// self-checking bench for the charge-target balance sequencer
`timescale 1ns/10ps

module acb_sequencer_test;
   localparam int STEP = 20;
   localparam int SEC = 10;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic cmd_en = 1'b0;
   logic cmd_inh = 1'b0;
   logic scan_req, scan_done, run, done, wdog, sleep;
   logic [15:0] rdata, v;
   logic [13:0] en;
   logic [7:0] dly = 8'h00;
   acb_pkg::acb_reg_req_type req = '0;
   acb_pkg::acb_volt_arr_type volt_in, scan_volt;
   int fails = 0;
   int checks_done = 0;

   // shortened time bases keep the run to a few hundred cycles
   acb_sequencer #(.STEP_CYCLES(STEP), .SEC_CYCLES(SEC), .LEAD_CYCLES(4),
      .WDOG_TICK_CYCLES(50)) i_acb_sequencer (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
      .reg_req(req), .reg_rdata(rdata), .cmd_balance_enable(cmd_en),
      .cmd_balance_inhibit(cmd_inh), .scan_req(scan_req), .scan_done(scan_done),
      .scan_volt(scan_volt), .cell_balance_en(en), .balance_run_bit(run),
      .balance_done_flag(done), .wdog_timeout_flag(wdog), .sleep_req(sleep));

   acb_scan_model i_acb_scan_model (.ref_clk(ref_clk), .rst_n(rst_n), .scan_req(scan_req),
      .resp_delay(dly), .volt_in(volt_in), .scan_done(scan_done), .scan_volt(scan_volt));

   // 10 MHz clock
   always #50 ref_clk = ~ref_clk;

   // verdict and end of run
   task automatic results();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one sampled cycle of a bounded wait; running out of bound ends the run
   task automatic step(inout int n);
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 400) begin
         fails++;
         $display("[FAIL] wait_bound expected %0d seen %0d", 400, n);
         results();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask

   // read data lands on the edge that takes the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
      rd(a, v);
      chk(what, v, exp);
   endtask

   task automatic cmd(input bit inhibit);
      @(posedge ref_clk);
      if (inhibit) cmd_inh <= 1'b1;
      else cmd_en <= 1'b1;
      @(posedge ref_clk);
      cmd_inh <= 1'b0;
      cmd_en <= 1'b0;
      #1;
   endtask

   // follow one balance cycle: pattern, on-time, scan with outputs off, rest gap
   task automatic cyc(input logic [13:0] exp_en, input bit chk_on, input bit chk_rest);
      int n;
      n = 0;
      while (en === 14'h0000) step(n);
      chk("pattern", {2'h0, en}, {2'h0, exp_en});
      n = 0;
      while (en === exp_en) step(n);
      if (chk_on) chk("on_time", 16'(n), 16'(3 * STEP));
      n = 0;
      while (scan_req !== 1'b1) step(n);
      chk("scan_outputs", {2'h0, en}, 16'h0000);
      n = 0;
      while (scan_req === 1'b1) step(n);
      n = 0;
      while (scan_req !== 1'b1 && en === 14'h0000 && run === 1'b1) step(n);
      if (chk_rest) chk("rest_time", 16'(n), 16'(8 * SEC));
   endtask

   initial begin
      for (int i = 0; i < acb_pkg::NCELL; i++) volt_in[i] = 14'h0100;
      // oversized reading on cell 2 to force the clamp
      volt_in[1] = 14'h3FFF;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd_chk("setup_reset", acb_pkg::ADDR_SETUP, 16'h0000);
      rd_chk("guard_reset", acb_pkg::ADDR_GUARD, 16'h003F);
      rd_chk("unmapped", 8'h92, 16'h0000);
      // program before enable; targets already in code units
      for (int i = 0; i < acb_pkg::NCELL; i++) begin
         wr(acb_pkg::ADDR_TGT_BASE + 8'(i), (i == 0) ? 16'h0002 : (i == 1) ? 16'h0003 : 16'h0000);
         wr(acb_pkg::ADDR_PAT_BASE + 8'(i), (i == 0) ? 16'h1249 : (i == 1) ? 16'h2492 : 16'h0000);
      end
      wr(8'hAD, 16'hFFFF);
      rd_chk("tgt_full_width", 8'hAD, 16'hFFFF);
      wr(8'hAD, 16'h0000);
      for (int i = 0; i < 2; i++) begin
         rd_chk("target", acb_pkg::ADDR_TGT_BASE + 8'(i), 16'(i + 2));
         rd_chk("pattern_reg", acb_pkg::ADDR_PAT_BASE + 8'(i), i ? 16'h2492 : 16'h1249);
      end
      // method 10 must not start the engine
      wr(acb_pkg::ADDR_SETUP, 16'h0052);
      cmd(1'b0);
      chk("wrong_method", {15'h0, run}, 16'h0000);
      wr(acb_pkg::ADDR_SETUP, 16'h0053);
      wr(acb_pkg::ADDR_GUARD, 16'h033F);
      cmd(1'b0);
      // cell 4 has a zero target and must stay off
      chk("first_outputs", {2'h0, en}, 16'h0001);
      cyc(14'h0001, 1'b1, 1'b1);
      cyc(14'h0002, 1'b0, 1'b0);
      cyc(14'h0001, 1'b0, 1'b0);
      chk("done_flag", {15'h0, done}, 16'h0001);
      chk("run_cleared", {15'h0, run}, 16'h0000);
      chk("outputs_off", {2'h0, en}, 16'h0000);
      rd_chk("cell1_spent", acb_pkg::ADDR_TGT_BASE, 16'h0000);
      rd_chk("cell2_clamped", 8'hA1, 16'h0000);
      rd_chk("setup_after", acb_pkg::ADDR_SETUP, 16'h0053);
      // second run: no rest, slow scans, interrupted in pattern two
      volt_in[1] = 14'h0100;
      dly <= 8'h05;
      wr(acb_pkg::ADDR_TGT_BASE, 16'h0005);
      wr(8'hA1, 16'h0005);
      wr(acb_pkg::ADDR_SETUP, 16'h0043);
      cmd(1'b0);
      chk("done_cleared", {15'h0, done}, 16'h0000);
      cyc(14'h0001, 1'b1, 1'b0);
      chk("second_pattern", {2'h0, en}, 16'h0002);
      cmd(1'b1);
      chk("inhibit_run", {15'h0, run}, 16'h0000);
      chk("inhibit_outputs", {2'h0, en}, 16'h0000);
      rd_chk("partial_subtract", acb_pkg::ADDR_TGT_BASE, 16'h0004);
      rd_chk("kept_target", 8'hA1, 16'h0005);
      cmd(1'b0);
      chk("restart_pattern", {2'h0, en}, 16'h0001);
      rd_chk("setup_running", acb_pkg::ADDR_SETUP, 16'h0063);
      // clock enable low must freeze the on-time past its normal end
      @(posedge ref_clk);
      ce <= 1'b0;
      repeat (70) @(posedge ref_clk);
      #1;
      chk("ce_freeze", {2'h0, en}, 16'h0001);
      @(posedge ref_clk);
      ce <= 1'b1;
      // watchdog of one tick with the link left quiet
      wr(acb_pkg::ADDR_GUARD, 16'h0301);
      begin
         int n;
         n = 0;
         while (wdog !== 1'b1) step(n);
      end
      chk("wdog_run", {15'h0, run}, 16'h0000);
      chk("wdog_sleep", {15'h0, sleep}, 16'h0001);
      chk("wdog_outputs", {2'h0, en}, 16'h0000);
      results();
   end
endmodule
